// [hdl/word_access_consts.svh]
// Purpose: shared constants of the word-access serial target and its master
// Assumes: one 40 MHz clock on both ends
// Notes: timing counts are derived from times in their own units
//
// Contract
// - target answers only bus address 0x0A
// - read address byte reads 0x15
// - write address byte reads 0x14
// - master sends command byte, then data
// - every access moves exactly two bytes
// - low byte first, high byte second
// - bits go most significant first
// - user conversion stores data, sets valid
// - source write clears valid, keeps data
// - reading result clears valid
// - source tag changes only with new data
// - four-slot conversion sequence repeats
// - three-bit source select, 2 is diode voltage
`ifndef WORD_ACCESS_CONSTS_SVH
`define WORD_ACCESS_CONSTS_SVH
`define TGT_ADDR 7'h0a
`define ADDR_RD_BYTE 8'h15
`define ADDR_WR_BYTE 8'h14
`define CMD_USER_RESULT 8'h10
`define BYTE_BITS 4'h8
`define RES_VALID_BIT 15
`define RES_SRC_LSB 10
`define RES_SRC_MSB 12
`define RES_DATA_MSB 9
`define SRC_SOURCE_CUR 3'h0
`define SRC_MOD_CUR 3'h1
`define SRC_LASER_DIODE_VOLTAGE 3'h2
`define SRC_MONITOR_CUR 3'h3
`define SRC_TERM_VOLTAGE 3'h4
`define SRC_DIE_TEMP 3'h5
`define SLOT_USER 2'h3
`define REF_CLK_MHZ 40
`define CONV_TIME_US 1000
`define CONV_CYC (`CONV_TIME_US * `REF_CLK_MHZ)
`define SCL_QUARTER_NS 2500
`define SCL_QUARTER_CYC ((`SCL_QUARTER_NS * `REF_CLK_MHZ + 999) / 1000)
`endif

// [hdl/word_access_pkg.sv]
// Purpose: types shared by both ends of the word-access link
// Assumes: constants come from word_access_consts.svh
// Notes: state enums carry no codes
package word_access_pkg;
	typedef logic [15:0] word_t;
	typedef logic [7:0] byte_t;
	typedef enum logic [3:0] {DS_IDLE, DS_ADDR, DS_AACK, DS_CMD, DS_CACK, DS_WDATA, DS_WACK,
		DS_RDATA, DS_RACK} dev_state_t;
	typedef enum logic [2:0] {HS_IDLE, HS_START, HS_BIT, HS_RSTART, HS_STOP} host_state_t;
endpackage

// [hdl/word_bus_if.sv]
// Purpose: two-wire open-drain link between master and target
// Assumes: each end drives low only while its enable is high
// Notes: the target never stretches the clock, so it only reads it
`timescale 1ns/1ps
interface word_bus_if;
	logic host_scl_oe; // master pulls clock low
	logic host_sda_oe; // master pulls data low
	logic dev_sda_oe; // target pulls data low
	logic scl; // resolved clock level
	logic sda; // resolved data level
	// wired-and with pull-ups
	assign scl = ~host_scl_oe;
	assign sda = ~(host_sda_oe | dev_sda_oe);
	modport host (output host_scl_oe, output host_sda_oe, input scl, input sda);
	modport dev (output dev_sda_oe, input scl, input sda);
endinterface

// [hdl/word_target.sv]
// Purpose: target end: word register access and user conversion result
// Assumes: converter data is on the REF_CLK domain, valid at slot end
// Notes: bus pins are synchronised before any logic reads them
`timescale 1ns/1ps
`include "word_access_consts.svh"
module word_target #(
	parameter int CONV_CYCLES = `CONV_CYC
) (
	input wire logic REF_CLK,
	input wire logic RSTN,
	word_bus_if.dev BUS,
	input wire logic [9:0] CONV_DATA,
	input wire logic APC_MODE,
	output logic [1:0] ADC_SLOT,
	output logic [2:0] ADC_MUX_SEL
);
	localparam int TW = $clog2(CONV_CYCLES);
	// pin synchronisers and edge history
	logic scl_s1_reg, scl_s2_reg, scl_d_reg;
	logic sda_s1_reg, sda_s2_reg, sda_d_reg;
	logic rise, fall, start, stop; // bus events
	// link state
	word_access_pkg::dev_state_t state_reg, state_next;
	logic [7:0] sh_reg, sh_next; // shift register
	logic [3:0] cnt_reg, cnt_next; // bit counter
	logic [1:0] byte_reg, byte_next; // data byte index
	logic [7:0] lo_reg, lo_next; // low data byte held
	logic [7:0] cmd_reg, cmd_next; // selected register
	logic have_cmd_reg, have_cmd_next; // command seen this transfer
	logic mack_reg, mack_next; // master acked last byte
	logic sda_oe_reg, sda_oe_next;
	word_access_pkg::word_t rword_reg, rword_next; // word being read
	logic wr_sel; // pulse: source select written
	logic rd_clr; // pulse: result register read
	// conversion state
	logic [TW-1:0] tick_reg, tick_next;
	logic [1:0] slot_reg, slot_next;
	logic [2:0] mux_reg, mux_next;
	logic [2:0] sel_reg, sel_next; // user source select
	logic [2:0] src_reg, src_next; // source of held data
	logic [9:0] data_reg, data_next;
	logic valid_reg, valid_next;
	logic slot_end;

	// mux select for a slot; slot 2 depends on control mode, slot 3 takes the user select
	function automatic logic [2:0] slot_mux(input logic [1:0] s, input logic apc,
		input logic [2:0] sel);
		unique case (s)
			2'h0: slot_mux = `SRC_DIE_TEMP;
			2'h1: slot_mux = `SRC_MOD_CUR;
			2'h2: slot_mux = apc ? `SRC_MONITOR_CUR : `SRC_SOURCE_CUR;
			default: slot_mux = sel;
		endcase
	endfunction

	// read view; other commands read zero
	function automatic word_access_pkg::word_t read_word(input logic [7:0] c);
		read_word = '0;
		if (c == `CMD_USER_RESULT)
		begin
			read_word[`RES_VALID_BIT] = valid_reg;
			read_word[`RES_SRC_MSB:`RES_SRC_LSB] = src_reg;
			read_word[`RES_DATA_MSB:0] = data_reg;
		end
	endfunction

	// two flops per pin, then one more for edge detection
	always_ff @(posedge REF_CLK)
	begin
		scl_s1_reg <= BUS.scl;
		scl_s2_reg <= scl_s1_reg;
		sda_s1_reg <= BUS.sda;
		sda_s2_reg <= sda_s1_reg;
		scl_d_reg <= RSTN ? scl_s2_reg : 1'b1;
		sda_d_reg <= RSTN ? sda_s2_reg : 1'b1;
	end

	assign rise = scl_s2_reg & ~scl_d_reg;
	assign fall = ~scl_s2_reg & scl_d_reg;
	assign start = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
	assign stop = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

	// link sequencing; data changes only on falling clock edges
	always_comb
	begin
		state_next = state_reg;
		sh_next = sh_reg;
		cnt_next = cnt_reg;
		byte_next = byte_reg;
		lo_next = lo_reg;
		cmd_next = cmd_reg;
		have_cmd_next = have_cmd_reg;
		mack_next = mack_reg;
		sda_oe_next = sda_oe_reg;
		rword_next = rword_reg;
		wr_sel = 1'b0;
		rd_clr = 1'b0;
		if (start)
		begin
			// a repeated start keeps the command for the read
			state_next = word_access_pkg::DS_ADDR;
			cnt_next = '0;
			sda_oe_next = 1'b0;
		end
		else if (stop)
		begin
			state_next = word_access_pkg::DS_IDLE;
			have_cmd_next = 1'b0;
			sda_oe_next = 1'b0;
		end
		else
		begin
			unique case (state_reg)
				word_access_pkg::DS_IDLE: ; // wait for a start
				word_access_pkg::DS_ADDR, word_access_pkg::DS_CMD, word_access_pkg::DS_WDATA:
				begin
					if (rise && cnt_reg != `BYTE_BITS)
					begin
						sh_next = {sh_reg[6:0], sda_s2_reg};
						cnt_next = cnt_reg + 4'h1;
					end
					else if (fall && cnt_reg == `BYTE_BITS)
					begin
						cnt_next = '0;
						if (state_reg == word_access_pkg::DS_ADDR)
						begin
							if (sh_reg[7:1] == `TGT_ADDR && (!sh_reg[0] || have_cmd_reg))
							begin
								sda_oe_next = 1'b1;
								state_next = word_access_pkg::DS_AACK;
							end
							else
								state_next = word_access_pkg::DS_IDLE;
						end
						else if (state_reg == word_access_pkg::DS_CMD)
						begin
							cmd_next = sh_reg;
							have_cmd_next = 1'b1;
							sda_oe_next = 1'b1;
							state_next = word_access_pkg::DS_CACK;
						end
						else if (byte_reg == 2'h0)
						begin
							lo_next = sh_reg;
							sda_oe_next = 1'b1;
							state_next = word_access_pkg::DS_WACK;
						end
						else if (byte_reg == 2'h1)
						begin
							// high byte completes the word
							wr_sel = (cmd_reg == `CMD_USER_RESULT);
							sda_oe_next = 1'b1;
							state_next = word_access_pkg::DS_WACK;
						end
						else
							state_next = word_access_pkg::DS_IDLE;
					end
				end
				word_access_pkg::DS_AACK:
					if (fall)
					begin
						byte_next = '0;
						if (sh_reg[0])
						begin
							// read: load the word and put out its first bit
							rword_next = read_word(cmd_reg);
							rd_clr = (cmd_reg == `CMD_USER_RESULT);
							sh_next = rword_next[7:0];
							sda_oe_next = ~rword_next[7];
							state_next = word_access_pkg::DS_RDATA;
						end
						else
						begin
							sda_oe_next = 1'b0;
							state_next = word_access_pkg::DS_CMD;
						end
					end
				word_access_pkg::DS_CACK, word_access_pkg::DS_WACK:
					if (fall)
					begin
						sda_oe_next = 1'b0;
						if (state_reg == word_access_pkg::DS_CACK)
							byte_next = '0;
						else
							byte_next = byte_reg + 2'h1;
						state_next = word_access_pkg::DS_WDATA;
					end
				word_access_pkg::DS_RDATA:
					if (fall)
					begin
						cnt_next = cnt_reg + 4'h1;
						if (cnt_reg == `BYTE_BITS - 4'h1)
						begin
							sda_oe_next = 1'b0; // let the master answer
							state_next = word_access_pkg::DS_RACK;
						end
						else
						begin
							sda_oe_next = ~sh_reg[6];
							sh_next = {sh_reg[6:0], 1'b0};
						end
					end
				word_access_pkg::DS_RACK:
					if (rise)
						mack_next = ~sda_s2_reg;
					else if (fall)
					begin
						cnt_next = '0;
						if (mack_reg && byte_reg == 2'h0)
						begin
							byte_next = 2'h1;
							sh_next = rword_reg[15:8];
							sda_oe_next = ~rword_reg[15];
							state_next = word_access_pkg::DS_RDATA;
						end
						else
							state_next = word_access_pkg::DS_IDLE;
					end
			endcase
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RSTN)
		begin
			state_reg <= word_access_pkg::DS_IDLE;
			sh_reg <= '0;
			cnt_reg <= '0;
			byte_reg <= '0;
			lo_reg <= '0;
			cmd_reg <= '0;
			have_cmd_reg <= 1'b0;
			mack_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			rword_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			sh_reg <= sh_next;
			cnt_reg <= cnt_next;
			byte_reg <= byte_next;
			lo_reg <= lo_next;
			cmd_reg <= cmd_next;
			have_cmd_reg <= have_cmd_next;
			mack_reg <= mack_next;
			sda_oe_reg <= sda_oe_next;
			rword_reg <= rword_next;
		end
	end

	// conversion slots and the user result; a store beats a clear
	always_comb
	begin
		slot_end = (tick_reg == TW'(CONV_CYCLES - 1));
		tick_next = slot_end ? '0 : tick_reg + 1'b1;
		slot_next = slot_reg;
		mux_next = mux_reg;
		sel_next = sel_reg;
		src_next = src_reg;
		data_next = data_reg;
		valid_next = valid_reg;
		if (wr_sel)
		begin
			sel_next = lo_reg[2:0];
			valid_next = 1'b0;
		end
		if (rd_clr)
			valid_next = 1'b0;
		if (slot_end)
		begin
			slot_next = slot_reg + 2'h1;
			mux_next = slot_mux(slot_next, APC_MODE, sel_next);
			if (slot_reg == `SLOT_USER)
			begin
				data_next = CONV_DATA;
				src_next = mux_reg;
				valid_next = 1'b1;
			end
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RSTN)
		begin
			tick_reg <= '0;
			slot_reg <= '0;
			mux_reg <= `SRC_DIE_TEMP;
			sel_reg <= '0;
			src_reg <= '0;
			data_reg <= '0;
			valid_reg <= 1'b0;
		end
		else
		begin
			tick_reg <= tick_next;
			slot_reg <= slot_next;
			mux_reg <= mux_next;
			sel_reg <= sel_next;
			src_reg <= src_next;
			data_reg <= data_next;
			valid_reg <= valid_next;
		end
	end

	assign BUS.dev_sda_oe = sda_oe_reg;
	assign ADC_SLOT = slot_reg;
	assign ADC_MUX_SEL = mux_reg;
endmodule

// [hdl/word_master.sv]
// Purpose: master end: one word write or read per command
// Assumes: target never stretches the clock
// Notes: one bit takes four quarter ticks of the clock divider
`timescale 1ns/1ps
`include "word_access_consts.svh"
module word_master #(
	parameter int QUARTER = `SCL_QUARTER_CYC
) (
	input wire logic REF_CLK,
	input wire logic RSTN,
	word_bus_if.host BUS,
	input wire logic CMD_GO,
	input wire logic CMD_READ,
	input wire logic [7:0] CMD_CODE,
	input wire logic [15:0] CMD_WDATA,
	output logic BUSY,
	output logic DONE,
	output logic NACK,
	output logic [15:0] RDATA
);
	localparam int DW = $clog2(QUARTER + 1);
	logic sda_s1_reg, sda_s2_reg; // data pin synchroniser
	word_access_pkg::host_state_t hs_reg, hs_next;
	logic [DW-1:0] div_reg, div_next; // quarter tick divider
	logic [1:0] q_reg, q_next; // quarter within a bit
	logic [2:0] seq_reg, seq_next; // byte index in the transfer
	logic [3:0] bit_reg, bit_next; // bit index, eight is the ack slot
	logic [7:0] sh_reg, sh_next;
	logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
	logic rd_reg, rd_next;
	logic [7:0] code_reg, code_next;
	word_access_pkg::word_t wd_reg, wd_next, rdata_reg, rdata_next;
	logic busy_reg, busy_next, done_reg, done_next, nack_reg, nack_next;
	logic tick, recv, last;

	// byte sent at each position of a transfer
	function automatic logic [7:0] byte_for(input logic [2:0] s);
		unique case (s)
			3'h0: byte_for = `ADDR_WR_BYTE;
			3'h1: byte_for = code_reg;
			3'h2: byte_for = rd_reg ? `ADDR_RD_BYTE : wd_reg[7:0];
			3'h3: byte_for = wd_reg[15:8];
			default: byte_for = '0;
		endcase
	endfunction

	always_ff @(posedge REF_CLK)
	begin
		sda_s1_reg <= BUS.sda;
		sda_s2_reg <= sda_s1_reg;
	end

	// transfer sequencer, stepped by the quarter tick
	always_comb
	begin
		tick = (div_reg == DW'(QUARTER - 1));
		recv = rd_reg && seq_reg >= 3'h3;
		last = rd_reg ? (seq_reg == 3'h4) : (seq_reg == 3'h3);
		hs_next = hs_reg;
		div_next = tick ? '0 : div_reg + 1'b1;
		q_next = q_reg;
		seq_next = seq_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		scl_oe_next = scl_oe_reg;
		sda_oe_next = sda_oe_reg;
		rd_next = rd_reg;
		code_next = code_reg;
		wd_next = wd_reg;
		rdata_next = rdata_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		nack_next = nack_reg;
		if (hs_reg == word_access_pkg::HS_IDLE)
		begin
			div_next = '0;
			q_next = '0;
			if (CMD_GO)
			begin
				rd_next = CMD_READ;
				code_next = CMD_CODE;
				wd_next = CMD_WDATA;
				busy_next = 1'b1;
				nack_next = 1'b0;
				seq_next = '0;
				hs_next = word_access_pkg::HS_START;
			end
		end
		else if (tick)
		begin
			q_next = q_reg + 2'h1;
			unique case (hs_reg)
				word_access_pkg::HS_START, word_access_pkg::HS_RSTART:
					unique case (q_reg)
						2'h0: sda_oe_next = (hs_reg == word_access_pkg::HS_START);
						2'h1: scl_oe_next = 1'b0;
						2'h2: sda_oe_next = 1'b1; // repeated start: data falls, clock high
						2'h3:
						begin
							scl_oe_next = 1'b1;
							bit_next = '0;
							sh_next = byte_for(seq_reg);
							hs_next = word_access_pkg::HS_BIT;
						end
					endcase
				word_access_pkg::HS_BIT:
					unique case (q_reg)
						2'h0:
							if (bit_reg != `BYTE_BITS)
								sda_oe_next = recv ? 1'b0 : ~sh_reg[7];
							else
								sda_oe_next = recv && seq_reg == 3'h3;
						2'h1: scl_oe_next = 1'b0;
						2'h2:
							if (bit_reg != `BYTE_BITS)
								sh_next = {sh_reg[6:0], sda_s2_reg};
							else if (!recv && sda_s2_reg)
								nack_next = 1'b1;
						2'h3:
						begin
							scl_oe_next = 1'b1;
							bit_next = bit_reg + 4'h1;
							if (bit_reg == `BYTE_BITS)
							begin
								if (recv && seq_reg == 3'h3)
									rdata_next[7:0] = sh_reg;
								else if (recv)
									rdata_next[15:8] = sh_reg;
								seq_next = seq_reg + 3'h1;
								bit_next = '0;
								sh_next = byte_for(seq_next);
								if (nack_reg || last)
									hs_next = word_access_pkg::HS_STOP;
								else if (rd_reg && seq_reg == 3'h1)
									hs_next = word_access_pkg::HS_RSTART;
							end
						end
					endcase
				word_access_pkg::HS_STOP:
					unique case (q_reg)
						2'h0: sda_oe_next = 1'b1;
						2'h1: scl_oe_next = 1'b0;
						2'h2: sda_oe_next = 1'b0; // stop: data rises, clock high
						2'h3:
						begin
							busy_next = 1'b0;
							done_next = 1'b1;
							hs_next = word_access_pkg::HS_IDLE;
						end
					endcase
				default: hs_next = word_access_pkg::HS_IDLE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RSTN)
		begin
			hs_reg <= word_access_pkg::HS_IDLE;
			div_reg <= '0;
			q_reg <= '0;
			seq_reg <= '0;
			bit_reg <= '0;
			sh_reg <= '0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			rd_reg <= 1'b0;
			code_reg <= '0;
			wd_reg <= '0;
			rdata_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			nack_reg <= 1'b0;
		end
		else
		begin
			hs_reg <= hs_next;
			div_reg <= div_next;
			q_reg <= q_next;
			seq_reg <= seq_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			scl_oe_reg <= scl_oe_next;
			sda_oe_reg <= sda_oe_next;
			rd_reg <= rd_next;
			code_reg <= code_next;
			wd_reg <= wd_next;
			rdata_reg <= rdata_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			nack_reg <= nack_next;
		end
	end

	assign BUS.host_scl_oe = scl_oe_reg;
	assign BUS.host_sda_oe = sda_oe_reg;
	assign BUSY = busy_reg;
	assign DONE = done_reg;
	assign NACK = nack_reg;
	assign RDATA = rdata_reg;
endmodule

// [tb/word_bus_props.sv]
// Purpose: wire checks of the word-access link between master and target
// Assumes: one REF_CLK domain; the checker sees raw wire levels
// Notes: a read segment is recognised by the repeated start that opens it
`timescale 1ns/1ps
`include "word_access_consts.svh"
module word_bus_props (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic host_scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_reg, sda_reg; // last sampled wire levels
	logic busy_reg, busy_next; // between start and stop
	logic rep_reg, rep_next; // segment opened by a repeated start
	logic [3:0] bit_reg, bit_next; // bit index, 8 is the acknowledge
	logic [2:0] byte_reg, byte_next; // bytes since the last start
	logic [7:0] sh_reg, sh_next; // byte being shifted in
	logic rise, start, stop;
	assign rise = scl && !scl_reg;
	assign start = scl && scl_reg && sda_reg && !sda;
	assign stop = scl && scl_reg && !sda_reg && sda;
	// frame tracking; a start inside a frame marks the read segment
	always_comb
	begin
		busy_next = busy_reg;
		rep_next = rep_reg;
		bit_next = bit_reg;
		byte_next = byte_reg;
		sh_next = sh_reg;
		if (start)
		begin
			busy_next = 1'b1;
			rep_next = busy_reg;
			bit_next = 4'h0;
			byte_next = 3'h0;
		end
		else if (stop)
		begin
			busy_next = 1'b0;
			rep_next = 1'b0;
		end
		else if (rise && bit_reg == 4'h8)
		begin
			bit_next = 4'h0;
			byte_next = byte_reg + 3'h1;
		end
		else if (rise)
		begin
			bit_next = bit_reg + 4'h1;
			sh_next = {sh_reg[6:0], sda};
		end
	end
	// history and frame tracking registers
	always_ff @(posedge REF_CLK)
	begin
		if (!RSTN)
		begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			busy_reg <= 1'b0;
			rep_reg <= 1'b0;
			bit_reg <= 4'h0;
			byte_reg <= 3'h0;
			sh_reg <= 8'h00;
		end
		else
		begin
			scl_reg <= scl;
			sda_reg <= sda;
			busy_reg <= busy_next;
			rep_reg <= rep_next;
			bit_reg <= bit_next;
			byte_reg <= byte_next;
			sh_reg <= sh_next;
		end
	end
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!RSTN);
	a_quiet_idle: assert property (!busy_reg |-> !dev_sda_oe)
		else $error("target drove data outside a frame");
	a_addr_undriven: assert property (rise && byte_reg == 3'h0 && bit_reg < 4'h8 |-> !dev_sda_oe)
		else $error("target drove an address bit");
	a_edge_scl_low: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
		else $error("target changed data while clock high");
	a_write_addr_byte: assert property (rise && bit_reg == 4'h8 && byte_reg == 3'h0
		&& !rep_reg |-> sh_reg == `ADDR_WR_BYTE)
		else $error("write address byte wrong");
	a_read_addr_byte: assert property (rise && bit_reg == 4'h8 && byte_reg == 3'h0
		&& rep_reg |-> sh_reg == `ADDR_RD_BYTE)
		else $error("read address byte wrong");
	a_bytes_acked: assert property (rise && bit_reg == 4'h8
		&& (!rep_reg || byte_reg == 3'h0) |-> dev_sda_oe)
		else $error("target failed to acknowledge");
	a_low_byte_ack: assert property (rise && bit_reg == 4'h8 && rep_reg
		&& byte_reg == 3'h1 |-> host_sda_oe && !dev_sda_oe)
		else $error("low read byte not acknowledged by master");
	a_high_byte_nack: assert property (rise && bit_reg == 4'h8 && rep_reg
		&& byte_reg == 3'h2 |-> sda)
		else $error("high read byte acknowledged");
	a_two_data_bytes: assert property (stop |-> byte_reg == (rep_reg ? 3'h3 : 3'h4))
		else $error("frame did not carry two data bytes");
	cover property (stop && !rep_reg);
	cover property (stop && rep_reg);
	cover property (rise && bit_reg == 4'h8 && rep_reg && byte_reg == 3'h2);
endmodule

// [tb/testbench.sv]
// Purpose: end-to-end bench of master and target across the link
// Assumes: short slots and a fast bit clock, set by parameters
// Notes: expected words use valid 15, tag 12:10, data 9:0
`timescale 1ns/1ps
`include "word_access_consts.svh"
module testbench;
	localparam int CONV = 3000; // slot outlasts one read frame; keeps the run short
	logic clk = 1'b0, rstn = 1'b0;
	logic cmd_go = 1'b0, cmd_read = 1'b0, apc_mode = 1'b0;
	logic [7:0] cmd_code = 8'h00;
	logic [15:0] cmd_wdata = 16'h0000;
	logic [9:0] conv_data = 10'h2a5; // converter result seen by the user slot
	logic busy, done, nack;
	word_access_pkg::word_t rdata;
	logic [1:0] slot;
	logic [2:0] mux;
	int n_fail = 0, num_checks = 0, nb = 9; // nb 9 means no frame seen yet
	word_access_pkg::byte_t sh, fr_b[$]; // bytes seen on the wire
	logic fr_a[$]; // acknowledge level after each byte
	always #12.5 clk = ~clk;
	word_bus_if word_bus_if_i();
	word_master #(.QUARTER(8)) word_master_i (.REF_CLK(clk), .RSTN(rstn), .BUS(word_bus_if_i),
		.CMD_GO(cmd_go), .CMD_READ(cmd_read), .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata),
		.BUSY(busy), .DONE(done), .NACK(nack), .RDATA(rdata));
	word_target #(.CONV_CYCLES(CONV)) word_target_i (.REF_CLK(clk), .RSTN(rstn),
		.BUS(word_bus_if_i), .CONV_DATA(conv_data), .APC_MODE(apc_mode), .ADC_SLOT(slot),
		.ADC_MUX_SEL(mux));
	word_bus_props word_bus_props_i (.REF_CLK(clk), .RSTN(rstn),
		.host_scl_oe(word_bus_if_i.host_scl_oe), .host_sda_oe(word_bus_if_i.host_sda_oe),
		.dev_sda_oe(word_bus_if_i.dev_sda_oe), .scl(word_bus_if_i.scl), .sda(word_bus_if_i.sda));
	// start or repeated start restarts the bit count
	always @(negedge word_bus_if_i.sda)
		if (word_bus_if_i.scl === 1'b1)
			nb = 0;
	// bits taken on each clock rise; the ninth is the acknowledge
	always @(posedge word_bus_if_i.scl)
		if (nb < 8)
		begin
			sh = {sh[6:0], word_bus_if_i.sda};
			nb++;
		end
		else if (nb == 8)
		begin
			fr_b.push_back(sh);
			fr_a.push_back(word_bus_if_i.sda);
			nb = 0;
		end
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stall(input string what);
		n_fail++;
		$display("MISMATCH %s expected done seen timeout", what);
		conclude();
	endtask
	// one extra edge after the slot change; the mux code changes on the same edge as the slot
	task automatic wait_slot(input logic [1:0] s);
		int k;
		for (k = 0; k < 5 * CONV; k++)
		begin
			@(negedge clk);
			if (slot === s)
				break;
		end
		if (k == 5 * CONV)
			stall("slot");
		@(negedge clk);
	endtask
	// queues are cleared before GO so only this frame is judged
	task automatic run_cmd(input logic rd, input logic [7:0] code, input logic [15:0] wd);
		int k;
		fr_b.delete();
		fr_a.delete();
		@(posedge clk);
		cmd_go <= 1'b1;
		cmd_read <= rd;
		cmd_code <= code;
		cmd_wdata <= wd;
		@(posedge clk);
		cmd_go <= 1'b0;
		@(negedge clk);
		chk("busy flag", 16'h0001, {15'h0000, busy});
		for (k = 0; k < 4000; k++)
		begin
			@(negedge clk);
			if (done === 1'b1)
				break;
		end
		if (k == 4000)
			stall("frame");
		chk("busy flag", 16'h0000, {15'h0000, busy});
		chk("nack flag", 16'h0000, {15'h0000, nack});
	endtask
	// expected bytes packed with the first wire byte lowest; ack levels likewise
	task automatic chk_frame(input int n, input logic [39:0] eb, input logic [4:0] ea);
		int i;
		chk("frame bytes", 16'(n), 16'(fr_b.size()));
		for (i = 0; i < n; i++)
		begin
			chk("wire byte", {8'h00, eb[8*i +: 8]}, {8'h00, fr_b[i]});
			chk("ack bit", {15'h0000, ea[i]}, {15'h0000, fr_a[i]});
		end
	endtask
	task automatic do_write(input logic [7:0] code, input logic [15:0] wd);
		run_cmd(1'b0, code, wd);
		chk_frame(4, {8'h00, wd[15:8], wd[7:0], code, `ADDR_WR_BYTE}, 5'h00);
	endtask
	task automatic do_read(input logic [7:0] code, input logic [15:0] ew);
		run_cmd(1'b1, code, 16'h0000);
		chk("read word", ew, rdata);
		chk_frame(5, {ew[15:8], ew[7:0], `ADDR_RD_BYTE, code, `ADDR_WR_BYTE}, 5'h10);
	endtask
	task automatic test_select();
		wait_slot(2'h3);
		wait_slot(2'h0);
		do_write(`CMD_USER_RESULT, {13'h0000, `SRC_TERM_VOLTAGE});
		wait_slot(2'h3);
		chk("user mux", {13'h0000, `SRC_TERM_VOLTAGE}, {13'h0000, mux});
		wait_slot(2'h0);
		@(posedge clk);
		conv_data <= 10'h15a;
		do_write(`CMD_USER_RESULT, {13'h0000, `SRC_LASER_DIODE_VOLTAGE});
		do_read(`CMD_USER_RESULT, {3'h0, `SRC_TERM_VOLTAGE, 10'h2a5});
		$display("test select done");
	endtask
	task automatic test_result();
		wait_slot(2'h3);
		chk("user mux", {13'h0000, `SRC_LASER_DIODE_VOLTAGE}, {13'h0000, mux});
		wait_slot(2'h0);
		do_read(`CMD_USER_RESULT, {3'h4, `SRC_LASER_DIODE_VOLTAGE, 10'h15a});
		do_read(`CMD_USER_RESULT, {3'h0, `SRC_LASER_DIODE_VOLTAGE, 10'h15a});
		do_write(8'h33, 16'h0005);
		do_read(8'h33, 16'h0000);
		do_read(`CMD_USER_RESULT, {3'h0, `SRC_LASER_DIODE_VOLTAGE, 10'h15a});
		$display("test result done");
	endtask
	task automatic test_sequence();
		int a, s, n;
		logic [2:0] exp;
		for (a = 0; a < 2; a++)
		begin
			@(posedge clk);
			apc_mode <= a[0];
			wait_slot(2'h3);
			for (s = 0; s < 4; s++)
			begin
				wait_slot(s[1:0]);
				exp = (s == 0) ? `SRC_DIE_TEMP : (s == 1) ? `SRC_MOD_CUR :
					(s == 3) ? `SRC_LASER_DIODE_VOLTAGE : a[0] ? `SRC_MONITOR_CUR : `SRC_SOURCE_CUR;
				chk("slot mux", {13'h0000, exp}, {13'h0000, mux});
				if (s == 1)
				begin
					// counting starts two edges into the slot, so a full slot reads CONV - 2
					for (n = 0; n < CONV + 2; n++)
					begin
						@(negedge clk);
						if (slot !== 2'h1)
							break;
					end
					chk("slot length", 16'(CONV - 2), 16'(n));
				end
			end
		end
		$display("test sequence done");
	endtask
	// reset, then the scenarios in slot order
	initial
	begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		test_select();
		test_result();
		test_sequence();
		conclude();
	end
endmodule
